// ===== src/pfm_regs.svh
// constants for the permanent fault persistence monitor
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH
`define PFM_CLK_HZ 32'h017D7840
`define PFM_TICK_S 32'h00000001
`define PFM_TICK_CYCLES (`PFM_CLK_HZ * `PFM_TICK_S)
`define PFM_CHG_THR_DEF 16'sh0014
`define PFM_CHG_THR_MIN 16'sh000A
`define PFM_CHG_THR_MAX 16'sh1388
`define PFM_DSG_THR_DEF (-16'sh0014)
`define PFM_DSG_THR_MIN (-16'sh1388)
`define PFM_DSG_THR_MAX (-16'sh000A)
`define PFM_GND_THR_DEF 16'sh0064
`define PFM_GND_THR_MIN 16'sh0001
`define PFM_GND_THR_MAX 16'sh7FFF
`define PFM_DELAY_DEF 8'h05
`define PFM_NUM_FAULTS 6
`define PFM_IDX_CHG 0
`define PFM_IDX_DSG 1
`define PFM_IDX_GND 2
`define PFM_IDX_PROT 3
`define PFM_IDX_OSC 4
`define PFM_IDX_MUX 5
`endif

// ===== src/pfm_pkg.sv
// types for the permanent fault persistence monitor
package pfm_pkg;
	typedef logic [7:0] pfm_delay_t;
	typedef logic signed [15:0] pfm_meas_t;
endpackage : pfm_pkg

// ===== src/pfm_persist.sv
// one persistence counter with latched trigger flag
module pfm_persist #(
	parameter int DW = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// evaluation
	input wire logic tick,
	input wire logic cond,
	input wire logic [DW-1:0] delay,
	// result
	output logic fault
);
	typedef struct packed {
		logic [DW-1:0] count;
		logic fault;
	} pfm_persist_state_t;

	pfm_persist_state_t st;
	pfm_persist_state_t next_st;

	always_comb begin
		next_st = st;
		if (tick) begin
			if (!cond) begin
				next_st.count = '0;
			end else begin
				// saturate so a long fault never wraps the count
				if (st.count != {DW{1'b1}}) begin
					next_st.count = st.count + 1'b1;
				end
				// delay of zero latches on the first failing evaluation
				if ((st.count + 1'b1) >= {1'b0, delay} || delay == '0) begin
					next_st.fault = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign fault = st.fault;
endmodule : pfm_persist

// ===== src/pfm_monitor.sv
// permanent fault persistence monitor top
`include "pfm_regs.svh"

// Functional notes
// - charge leak fault: current >= threshold for delay seconds with charge switch off
// - charge threshold signed 16-bit 10..5000 mA, delay 8-bit 0..255 s
// - discharge leak fault: current <= negative threshold for delay with discharge switch off
// - discharge threshold -5000..-10 mA, delay 8-bit 0..255 s, default 5
// - ground fault: ground channel count >= threshold for delay seconds
// - ground threshold 1..32767 counts, delay 8-bit default 5
// - protector input sampled each second; fault after asserted for delay seconds
// - oscillator fault after integrity error bit stays set for delay seconds
// - oscillator delay zero: switches off on failure regardless of enable
// - comparator mux fault when self-check keeps failing for delay seconds
module pfm_monitor #(
	parameter int TICK_CYCLES = `PFM_TICK_CYCLES
) (
	// clock, enable and reset
	input wire logic clk,
	input wire logic clk_en,
	input wire logic rst_b,
	// measurements
	input wire logic signed [15:0] current_ma,
	input wire logic signed [15:0] ground_adc_count,
	input wire logic charge_switch,
	input wire logic discharge_switch,
	input wire logic protector_input_a,
	input wire logic slow_oscillator_error,
	input wire logic mux_check_fail,
	// configuration
	input wire logic signed [15:0] chg_leak_threshold,
	input wire logic [7:0] chg_leak_delay,
	input wire logic signed [15:0] dsg_leak_threshold,
	input wire logic [7:0] dsg_leak_delay,
	input wire logic signed [15:0] ground_fail_threshold,
	input wire logic [7:0] ground_fail_delay,
	input wire logic [7:0] protector_delay,
	input wire logic [7:0] osc_delay,
	input wire logic [7:0] mux_delay,
	input wire logic [5:0] fault_enable_group_c,
	// results
	output logic charge_switch_leak_fault,
	output logic discharge_switch_leak_fault,
	output logic ground_channel_fault,
	output logic second_level_protector_fault,
	output logic slow_oscillator_fault,
	output logic comparator_mux_fault,
	output logic [5:0] fault_event,
	output logic switch_off_request
);
	// ****************************************
	// reset release
	// ****************************************
	logic [1:0] rst_sync;
	logic rst_int_b;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_int_b = rst_sync[1];

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [31:0] tick_cnt;
		logic tick;
		logic [5:0] flags_q;
		logic [5:0] event_q;
		logic off_req;
	} pfm_mon_state_t;

	pfm_mon_state_t st;
	pfm_mon_state_t next_st;
	logic [5:0] cond;
	logic [5:0] raw_fault;
	logic [5:0] en_fault;
	pfm_pkg::pfm_meas_t chg_thr;
	pfm_pkg::pfm_meas_t dsg_thr;
	pfm_pkg::pfm_meas_t gnd_thr;

	// out-of-range settings are clamped into their legal span
	always_comb begin
		chg_thr = chg_leak_threshold;
		if (chg_thr < `PFM_CHG_THR_MIN) begin
			chg_thr = `PFM_CHG_THR_MIN;
		end
		if (chg_thr > `PFM_CHG_THR_MAX) begin
			chg_thr = `PFM_CHG_THR_MAX;
		end
		dsg_thr = dsg_leak_threshold;
		if (dsg_thr < `PFM_DSG_THR_MIN) begin
			dsg_thr = `PFM_DSG_THR_MIN;
		end
		if (dsg_thr > `PFM_DSG_THR_MAX) begin
			dsg_thr = `PFM_DSG_THR_MAX;
		end
		// upper bound of this span is the signed maximum itself
		gnd_thr = ground_fail_threshold;
		if (gnd_thr < `PFM_GND_THR_MIN) begin
			gnd_thr = `PFM_GND_THR_MIN;
		end
	end

	// ****************************************
	// fault conditions
	// ****************************************
	always_comb begin
		cond = '0;
		cond[`PFM_IDX_CHG] = !charge_switch && (current_ma >= chg_thr);
		cond[`PFM_IDX_DSG] = !discharge_switch && (current_ma <= dsg_thr);
		cond[`PFM_IDX_GND] = ground_adc_count >= gnd_thr;
		cond[`PFM_IDX_PROT] = protector_input_a;
		cond[`PFM_IDX_OSC] = slow_oscillator_error;
		cond[`PFM_IDX_MUX] = mux_check_fail;
	end

	// ****************************************
	// persistence counters, one per fault
	// ****************************************
	pfm_persist #(.DW(8)) u_persist_chg (
		.clk(clk),
		.rst_b(rst_int_b),
		.clk_en(clk_en),
		.tick(st.tick),
		.cond(cond[`PFM_IDX_CHG]),
		.delay(chg_leak_delay),
		.fault(raw_fault[`PFM_IDX_CHG])
	);

	pfm_persist #(.DW(8)) u_persist_dsg (
		.clk(clk),
		.rst_b(rst_int_b),
		.clk_en(clk_en),
		.tick(st.tick),
		.cond(cond[`PFM_IDX_DSG]),
		.delay(dsg_leak_delay),
		.fault(raw_fault[`PFM_IDX_DSG])
	);

	pfm_persist #(.DW(8)) u_persist_gnd (
		.clk(clk),
		.rst_b(rst_int_b),
		.clk_en(clk_en),
		.tick(st.tick),
		.cond(cond[`PFM_IDX_GND]),
		.delay(ground_fail_delay),
		.fault(raw_fault[`PFM_IDX_GND])
	);

	pfm_persist #(.DW(8)) u_persist_prot (
		.clk(clk),
		.rst_b(rst_int_b),
		.clk_en(clk_en),
		.tick(st.tick),
		.cond(cond[`PFM_IDX_PROT]),
		.delay(protector_delay),
		.fault(raw_fault[`PFM_IDX_PROT])
	);

	pfm_persist #(.DW(8)) u_persist_osc (
		.clk(clk),
		.rst_b(rst_int_b),
		.clk_en(clk_en),
		.tick(st.tick),
		.cond(cond[`PFM_IDX_OSC]),
		.delay(osc_delay),
		.fault(raw_fault[`PFM_IDX_OSC])
	);

	pfm_persist #(.DW(8)) u_persist_mux (
		.clk(clk),
		.rst_b(rst_int_b),
		.clk_en(clk_en),
		.tick(st.tick),
		.cond(cond[`PFM_IDX_MUX]),
		.delay(mux_delay),
		.fault(raw_fault[`PFM_IDX_MUX])
	);

	// a disabled fault is still counted but never reported
	assign en_fault = raw_fault & fault_enable_group_c;

	// ****************************************
	// tick, events and switch-off
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.tick_cnt >= TICK_CYCLES - 1) begin
			next_st.tick_cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 32'h1;
		end
		next_st.flags_q = en_fault;
		next_st.event_q = en_fault & ~st.flags_q;
		next_st.off_req = st.off_req | en_fault[`PFM_IDX_OSC];
		// zero delay: switch off at once, bypassing the enable
		if (osc_delay == 8'h00 && slow_oscillator_error) begin
			next_st.off_req = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign charge_switch_leak_fault = st.flags_q[`PFM_IDX_CHG];
	assign discharge_switch_leak_fault = st.flags_q[`PFM_IDX_DSG];
	assign ground_channel_fault = st.flags_q[`PFM_IDX_GND];
	assign second_level_protector_fault = st.flags_q[`PFM_IDX_PROT];
	assign slow_oscillator_fault = st.flags_q[`PFM_IDX_OSC];
	assign comparator_mux_fault = st.flags_q[`PFM_IDX_MUX];
	assign fault_event = st.event_q;
	assign switch_off_request = st.off_req;
endmodule : pfm_monitor

// ===== test/pfm_far_side.sv
// far-side model: measurement front end, switch drivers, protector
module pfm_far_side (
	// requested fault conditions
	input wire logic [5:0] cond,
	// toward the monitor
	output logic signed [15:0] current_ma,
	output logic signed [15:0] ground_adc_count,
	output logic charge_switch,
	output logic discharge_switch,
	output logic protector_input_a,
	output logic slow_oscillator_error,
	output logic mux_check_fail
);
	// exactly on threshold, so an exclusive compare would miss it
	assign current_ma = cond[0] ? 16'sh0014 : (cond[1] ? -16'sh0014 : 16'sh0000);
	assign charge_switch = !cond[0];
	assign discharge_switch = !cond[1];
	assign ground_adc_count = cond[2] ? 16'sh0064 : 16'sh0063;
	assign protector_input_a = cond[3];
	assign slow_oscillator_error = cond[4];
	assign mux_check_fail = cond[5];
endmodule : pfm_far_side

// ===== test/pfm_monitor_properties.sv
// port checker for the persistence monitor
module pfm_monitor_properties (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// causes
	input wire logic charge_switch,
	input wire logic discharge_switch,
	input wire logic protector_input_a,
	input wire logic slow_oscillator_error,
	input wire logic mux_check_fail,
	input wire logic [7:0] osc_delay,
	input wire logic [5:0] fault_enable_group_c,
	// results
	input wire logic charge_switch_leak_fault,
	input wire logic discharge_switch_leak_fault,
	input wire logic second_level_protector_fault,
	input wire logic comparator_mux_fault,
	input wire logic [5:0] fault_event,
	input wire logic switch_off_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_FLAG_STICKY: assert property (charge_switch_leak_fault |=> charge_switch_leak_fault)
		else $error("flag dropped");
	AST_EVENT_PULSE: assert property (fault_event[3] |=> !fault_event[3])
		else $error("event too long");
	AST_EVENT_FLAG: assert property (fault_event[0] |-> charge_switch_leak_fault)
		else $error("event without flag");
	AST_ENABLE_GATE: assert property (charge_switch_leak_fault |-> fault_enable_group_c[0])
		else $error("disabled flag shown");
	AST_OSC_ZERO: assert property ($past(rst_b, 3) && osc_delay == 8'h00 && slow_oscillator_error |=> switch_off_request)
		else $error("no switch off");
	AST_SOR_STICKY: assert property (switch_off_request |=> switch_off_request)
		else $error("switch off dropped");
	AST_PROT_CAUSE: assert property ($rose(second_level_protector_fault) |-> $past(protector_input_a, 2))
		else $error("protector flag without input");
	AST_MUX_CAUSE: assert property ($rose(comparator_mux_fault) |-> $past(mux_check_fail, 2))
		else $error("mux flag without failure");
	AST_CHG_CAUSE: assert property ($rose(charge_switch_leak_fault) |-> !$past(charge_switch, 2))
		else $error("charge flag with switch on");
	AST_DSG_CAUSE: assert property ($rose(discharge_switch_leak_fault) |-> !$past(discharge_switch, 2))
		else $error("discharge flag with switch on");
endmodule : pfm_monitor_properties

bind pfm_monitor pfm_monitor_properties pfm_monitor_properties_inst (.*);

// ===== test/tb_top.sv
// self-checking bench for the persistence monitor
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int T = 4;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] c = 6'h00;
	logic [5:0] en = 6'h3F;
	logic ce = 1'b1;
	logic [7:0] dly = 8'h02;
	logic [7:0] od = 8'h02;
	logic [5:0] f;
	logic [5:0] ev;
	logic sor;
	logic signed [15:0] cur;
	logic signed [15:0] gnd;
	logic chs, dss, pa, oe, mf;
	int n_fail = 0;
	int n_compared = 0;
	pfm_far_side pfm_far_side_inst (.cond(c), .current_ma(cur), .ground_adc_count(gnd), .charge_switch(chs),
		.discharge_switch(dss), .protector_input_a(pa), .slow_oscillator_error(oe), .mux_check_fail(mf));
	pfm_monitor #(.TICK_CYCLES(T)) pfm_monitor_inst (.clk(clk), .clk_en(ce), .rst_b(rst_b), .current_ma(cur),
		.ground_adc_count(gnd), .charge_switch(chs), .discharge_switch(dss), .protector_input_a(pa),
		.slow_oscillator_error(oe), .mux_check_fail(mf), .chg_leak_threshold(16'sh0014), .chg_leak_delay(dly),
		.dsg_leak_threshold(-16'sh0014), .dsg_leak_delay(dly), .ground_fail_threshold(16'sh0064),
		.ground_fail_delay(dly), .protector_delay(dly), .osc_delay(od), .mux_delay(dly),
		.fault_enable_group_c(en), .charge_switch_leak_fault(f[0]), .discharge_switch_leak_fault(f[1]),
		.ground_channel_fault(f[2]), .second_level_protector_fault(f[3]), .slow_oscillator_fault(f[4]),
		.comparator_mux_fault(f[5]), .fault_event(ev), .switch_off_request(sor));
	initial forever #20 clk = ~clk;
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic do_reset(input logic [5:0] e);
		c = 6'h00;
		en = e;
		rst_b = 1'b0;
		repeat (10) @(posedge clk);
		#1 rst_b = 1'b1;
	endtask : do_reset
	// one fault held until it latches; latency is two sync edges, e ticks, a count edge and a flag edge
	task automatic run_fault(input int i, input int d);
		int n;
		int e;
		e = (d == 0) ? 1 : d;
		dly = 8'(d);
		od = 8'(d);
		do_reset(6'h3F);
		c = 6'h01 << i;
		for (n = 0; n < 1100 && f[i] !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n >= 1100) begin
			n_fail++;
			$display("fault %0d timed out", i);
			return;
		end
		check("latency", 16'(n), 16'(e * T + 4));
		check("event", 16'(ev), 16'(6'h01 << i));
		c = 6'h00;
		repeat (2 * T) @(posedge clk);
		#1 check("held", 16'(f), 16'(6'h01 << i));
		check("pulse", 16'(ev), 16'h0000);
		check("switch off", 16'(sor), 16'(i == 4));
		$display("fault %0d delay %0d done", i, d);
	endtask : run_fault
	task automatic break_streak();
		dly = 8'h02;
		od = 8'h02;
		do_reset(6'h3F);
		repeat (8) begin
			c = ~c;
			repeat (T) @(posedge clk);
			#1;
		end
		check("broken streak", 16'(f), 16'h0000);
		$display("broken streak done");
	endtask : break_streak
	// low enable freezes the tick, so nothing may latch until it returns
	task automatic freeze_hold();
		dly = 8'h01;
		od = 8'h01;
		do_reset(6'h3F);
		ce = 1'b0;
		c = 6'h04;
		repeat (4 * T) @(posedge clk);
		#1 check("frozen", 16'(f), 16'h0000);
		ce = 1'b1;
		repeat (T + 4) @(posedge clk);
		#1 check("thawed", 16'(f), 16'h0004);
		$display("freeze done");
	endtask : freeze_hold
	task automatic disabled_paths();
		od = 8'h00;
		do_reset(6'h2E);
		c = 6'h11;
		repeat (4 * T) @(posedge clk);
		#1 check("disabled", 16'(f), 16'h0000);
		check("osc zero off", 16'(sor), 16'h0001);
		$display("disabled paths done");
	endtask : disabled_paths
	initial begin
		do_reset(6'h3F);
		check("reset", 16'({f, ev, sor}), 16'h0000);
		run_fault(0, 255);
		run_fault(1, 2);
		run_fault(2, 2);
		run_fault(3, 0);
		run_fault(4, 1);
		run_fault(5, 3);
		break_streak();
		freeze_hold();
		disabled_paths();
		print_verdict();
	end
endmodule : tb_top
